// *** eos_cmd.sv ***
// module: serial command slice for status read, stored-option read-back and waveform nonvolatile ops
`timescale 1ns/100ps
// Functional notes
// - opcode 2F returns one status byte with bits 7, 6 and 3 zero
// - status bit 5 is high-voltage not-ready flag, zero after reset
// - status bit 4 is supply-below-level flag, zero after reset
// - status bit 2 mirrors internal busy, zero after reset
// - status bits 1:0 hold a fixed chip identification code
// - opcode 30 programs waveform settings into nonvolatile memory from display RAM
// - opcode 31 loads waveform settings from nonvolatile memory into working registers
// - busy output stays high while program or load runs
module eos_cmd #(
    parameter int PROG_CYC = eos_pkg::EOS_WS_PROG_CYC
) (
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    input  wire eos_pkg::eos_pins_type pins_i,
    output logic                      sda_o,
    output logic                      sda_oe_o,
    output logic                      busy_o,
    input  wire logic                 hv_not_ready_i,
    input  wire logic                 vci_low_i,
    input  wire eos_pkg::eos_opts_type opts_i,
    input  wire eos_pkg::eos_uid_type  uid_i,
    output logic                      ws_prog_o,
    output logic                      ws_load_o
);
    import eos_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    eos_pins_type  pin_s1_q;
    eos_pins_type  pin_s2_q;
    logic          scl_d_q;
    logic [2:0]    bit_q;
    logic [7:0]    rx_q;
    logic [7:0]    tx_q;
    logic [7:0]    cmd_q;
    logic [3:0]    idx_q;
    logic          hv_q;
    logic          vci_q;
    logic [15:0]   cnt_q;
    eos_state_type state_q;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            // serial clock idles high, so reset to that level to avoid a false edge
            pin_s1_q <= '{cs_n: 1'b1, scl: 1'b1, dc: 1'b0, sdi: 1'b0};
            pin_s2_q <= '{cs_n: 1'b1, scl: 1'b1, dc: 1'b0, sdi: 1'b0};
            scl_d_q  <= 1'b1;
        end else begin
            pin_s1_q <= pins_i;
            pin_s2_q <= pin_s1_q;
            scl_d_q  <= pin_s2_q.scl;
        end
    end

    // ------------------------------------------------------------
    // byte framing and read-back selection
    // ------------------------------------------------------------
    logic                  scl_rise_w;
    logic                  byte_done_w;
    logic                  cmd_done_w;
    logic                  data_done_w;
    logic [7:0]            rx_byte_w;
    logic [7:0]            sel_cmd_w;
    logic [3:0]            sel_idx_w;
    logic [10:0][7:0]      opt_arr_w;
    logic [7:0]            opt_byte_w;
    logic [7:0]            uid_byte_w;
    logic [7:0]            status_w;
    logic [7:0]            stat_byte_w;
    logic [7:0]            rd_byte_w;
    logic                  rd_cmd_w;
    logic                  busy_w;

    assign scl_rise_w  = pin_s2_q.scl && !scl_d_q && !pin_s2_q.cs_n;
    assign byte_done_w = scl_rise_w && (bit_q == 3'h7);
    assign cmd_done_w  = byte_done_w && !pin_s2_q.dc;
    assign data_done_w = byte_done_w && pin_s2_q.dc;
    assign rx_byte_w   = {rx_q[6:0], pin_s2_q.sdi};
    // next byte to send: first byte of a new command, else the following one
    assign sel_cmd_w   = cmd_done_w ? rx_byte_w : cmd_q;
    assign sel_idx_w   = cmd_done_w ? EOS_IDX_RST : idx_q + 4'h1;

    assign busy_w      = (state_q != EOS_IDLE);
    assign status_w    = {2'b00, hv_q, vci_q, 1'b0, busy_w, EOS_CHIP_ID_DEF};

    // vcom selection sits in the top byte of the packed struct
    assign opt_arr_w   = opts_i;
    assign opt_byte_w  = (sel_idx_w < EOS_OPT_BYTES) ?
                         opt_arr_w[EOS_OPT_BYTES - 4'h1 - sel_idx_w] : 8'h00;
    assign uid_byte_w  = (sel_idx_w < EOS_UID_BYTES) ? uid_i[sel_idx_w] : 8'h00;

    // only the first data byte after the status command, and every 16th byte after it as the index wraps, carries the status
    assign stat_byte_w = (sel_idx_w == EOS_IDX_RST) ? status_w : 8'h00;
    assign rd_byte_w   = (sel_cmd_w == EOS_OP_STAT_READ) ? stat_byte_w :
                         (sel_cmd_w == EOS_OP_OPT_READ)  ? opt_byte_w :
                         (sel_cmd_w == EOS_OP_UID_READ)  ? uid_byte_w : 8'h00;
    assign rd_cmd_w    = (cmd_q == EOS_OP_STAT_READ) || (cmd_q == EOS_OP_OPT_READ) ||
                         (cmd_q == EOS_OP_UID_READ);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || pin_s2_q.cs_n) begin
            bit_q <= EOS_BIT_RST;
            rx_q  <= 8'h00;
        end else if (scl_rise_w) begin
            bit_q <= bit_q + 3'h1;
            rx_q  <= rx_byte_w;
        end
    end

    // host samples on the rising edge; shifting a few clocks later keeps the bit stable then
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cmd_q <= EOS_CMD_RST;
            idx_q <= EOS_IDX_RST;
            tx_q  <= 8'h00;
        end else if (byte_done_w) begin
            cmd_q <= sel_cmd_w;
            idx_q <= sel_idx_w;
            tx_q  <= rd_byte_w;
        end else if (scl_rise_w) begin
            tx_q  <= {tx_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sda_o    <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            sda_o    <= tx_q[7];
            sda_oe_o <= rd_cmd_w && pin_s2_q.dc && !pin_s2_q.cs_n;
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    // detection logic drives these on this clock, so no synchroniser
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            hv_q  <= 1'b0;
            vci_q <= 1'b0;
        end else begin
            hv_q  <= hv_not_ready_i;
            vci_q <= vci_low_i;
        end
    end

    // ------------------------------------------------------------
    // waveform program / load sequencer
    // ------------------------------------------------------------
    logic        start_prog_w;
    logic        start_load_w;
    logic        run_end_w;

    // a new program or load is ignored while one is running
    assign start_prog_w = cmd_done_w && (rx_byte_w == EOS_OP_WS_PROG) && !busy_w;
    assign start_load_w = cmd_done_w && (rx_byte_w == EOS_OP_WS_LOAD) && !busy_w;
    assign run_end_w    = busy_w && (cnt_q == 16'h0001);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_q <= EOS_IDLE;
            cnt_q   <= 16'h0000;
        end else begin
            case (state_q)
                EOS_IDLE: begin
                    if (start_prog_w) begin
                        state_q <= EOS_PROG;
                        cnt_q   <= 16'(PROG_CYC);
                    end else if (start_load_w) begin
                        state_q <= EOS_LOAD;
                        cnt_q   <= EOS_WS_LOAD_CYC;
                    end
                end
                default: begin
                    cnt_q <= cnt_q - 16'h0001;
                    if (run_end_w) begin
                        state_q <= EOS_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            busy_o    <= 1'b0;
            ws_prog_o <= 1'b0;
            ws_load_o <= 1'b0;
        end else begin
            busy_o    <= (start_prog_w || start_load_w || busy_w) && !run_end_w;
            ws_prog_o <= start_prog_w || (state_q == EOS_PROG && !run_end_w);
            ws_load_o <= start_load_w || (state_q == EOS_LOAD && !run_end_w);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_status_zero_bits: assert property (data_done_w && cmd_q == EOS_OP_STAT_READ && idx_q == 4'h0
        |=> tx_q == 8'h00) else $error("status framing broken");
    a_status_fixed_bits: assert property (cmd_done_w && rx_byte_w == EOS_OP_STAT_READ
        |=> tx_q[7:6] == 2'b00 && tx_q[3] == 1'b0) else $error("status reserved bits set");
    a_hv_flag_track: assert property (cmd_done_w && rx_byte_w == EOS_OP_STAT_READ
        |=> tx_q[5] == $past(hv_q)) else $error("hv flag wrong in status");
    a_vci_flag_track: assert property (##1 vci_q == $past(vci_low_i))
        else $error("supply flag not tracking");
    a_busy_mirror: assert property (cmd_done_w && rx_byte_w == EOS_OP_STAT_READ
        |=> tx_q[2] == $past(busy_w)) else $error("busy bit not mirrored");
    a_chip_id_fixed: assert property (cmd_done_w && rx_byte_w == EOS_OP_STAT_READ
        |=> tx_q[1:0] == EOS_CHIP_ID_DEF) else $error("chip id wrong");
    a_prog_start: assert property (start_prog_w |=> busy_o && ws_prog_o && !ws_load_o)
        else $error("program did not start");
    a_load_start: assert property (start_load_w |=> busy_o && ws_load_o [*2])
        else $error("load did not start");
    a_busy_release: assert property (run_end_w |=> !busy_o && !ws_prog_o && !ws_load_o)
        else $error("busy not released");
    a_busy_hold: assert property (busy_w && !run_end_w |=> busy_o)
        else $error("busy dropped early");
    a_opt_order: assert property (data_done_w && cmd_q == EOS_OP_OPT_READ && idx_q == 4'h1
        |=> tx_q == $past(opts_i.disp_mode[4])) else $error("option order wrong");
    a_uid_order: assert property (cmd_done_w && rx_byte_w == EOS_OP_UID_READ
        |=> tx_q == $past(uid_i[0])) else $error("user id order wrong");

    c_status_read: cover property (cmd_done_w && rx_byte_w == EOS_OP_STAT_READ ##[1:200] data_done_w);
    c_prog_done:   cover property (start_prog_w ##[1:1000] !busy_o);
    c_load_done:   cover property (start_load_w ##[1:600] !busy_o);
    c_uid_last:    cover property (data_done_w && cmd_q == EOS_OP_UID_READ && idx_q == 4'h9);

endmodule : eos_cmd

// *** eos_cmd_tb.sv ***
// self-checking bench for the status, read-back and waveform command slice
`timescale 1ns/100ps
module eos_cmd_tb;
    import eos_pkg::*;

    localparam int PROG = 300;
    localparam int LOAD = int'(EOS_WS_LOAD_CYC);

    logic         sys_clk_i, rst_n_i, hv, input_supply, sda, sda_oe, busy, ws_prog, ws_load;
    eos_pins_type pins;
    eos_opts_type opts;
    eos_uid_type  uid;
    int           fails, total_checks, cyc, busy_cyc, prog_cyc, load_cyc;
    logic [7:0]   rx;
    logic [7:0]   exp_q[$];

    eos_cmd #(.PROG_CYC(PROG)) DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .pins_i(pins),
        .sda_o(sda), .sda_oe_o(sda_oe), .busy_o(busy), .hv_not_ready_i(hv),
        .vci_low_i(input_supply), .opts_i(opts), .uid_i(uid), .ws_prog_o(ws_prog), .ws_load_o(ws_load));
    eos_host host (.sys_clk_i(sys_clk_i), .sda_i(sda), .sda_oe_i(sda_oe), .pins_o(pins));

    // ------------------------------------------------------------
    // clock, timeout and level counters
    // ------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        cyc      <= cyc + 1;
        busy_cyc <= busy_cyc + int'(busy);
        prog_cyc <= prog_cyc + int'(ws_prog);
        load_cyc <= load_cyc + int'(ws_load);
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // reads n data bytes after a command and pops the model's bytes
    task automatic run_read(input logic [7:0] op, input int n);
        host.select(1'b1);
        host.xfer(1'b0, op, rx);
        for (int k = 0; k < n; k++) begin
            host.xfer(1'b1, 8'h00, rx);
            check({8'h00, rx}, {8'h00, (exp_q.size() > 0) ? exp_q.pop_front() : 8'h00}, "byte");
        end
        host.select(1'b0);
    endtask : run_read

    function automatic logic [7:0] status_byte(input logic b);
        return {2'b00, hv, input_supply, 1'b0, b, EOS_CHIP_ID_DEF};
    endfunction : status_byte

    task automatic run_op(input logic [7:0] op, input int len, input int pl, input int ll);
        busy_cyc = 0;
        prog_cyc = 0;
        load_cyc = 0;
        hv       = 1'($urandom);
        input_supply      = 1'($urandom);
        // stored contents and clock stage are taken as prepared here
        host.select(1'b1);
        host.xfer(1'b0, op, rx);
        host.xfer(1'b0, (op == EOS_OP_WS_PROG) ? EOS_OP_WS_LOAD : EOS_OP_WS_PROG, rx);
        host.xfer(1'b0, EOS_OP_STAT_READ, rx);
        host.xfer(1'b1, 8'h00, rx);
        check({8'h00, rx}, {8'h00, status_byte(1'b1)}, "busy status");
        host.select(1'b0);
        for (int w = 0; w < 1000 && busy !== 1'b0; w++) host.ticks(1);
        host.ticks(2);
        check(16'(busy_cyc), 16'(len), "busy length");
        check(16'(prog_cyc), 16'(pl), "program length");
        check(16'(load_cyc), 16'(ll), "load length");
    endtask : run_op

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h0000_b926));
        rst_n_i      = 1'b0;
        hv           = 1'b0;
        input_supply          = 1'b0;
        cyc          = 0;
        fails        = 0;
        total_checks = 0;
        opts         = '0;
        uid          = '0;
        repeat (2) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        check({13'h0000, busy, ws_prog, ws_load}, 16'h0000, "reset levels");
        host.ticks(4);
        opts.vcom_sel = 8'($urandom);
        opts.vcom_reg = 8'($urandom);
        for (int k = 0; k < 5; k++) opts.disp_mode[k] = 8'($urandom);
        for (int k = 0; k < 4; k++) opts.ws_version[k] = 8'($urandom);
        for (int k = 0; k < 10; k++) uid[k] = 8'($urandom);
        // flags only read after the detection steps have set them
        for (int f = 0; f < 4; f++) begin
            hv  = f[1];
            input_supply = f[0];
            host.ticks(3);
            exp_q.push_back(status_byte(1'b0));
            run_read(EOS_OP_STAT_READ, 2);
        end
        for (int k = 10; k >= 0; k--) exp_q.push_back(opts[k*8 +: 8]);
        run_read(EOS_OP_OPT_READ, 12);
        for (int k = 0; k < 10; k++) exp_q.push_back(uid[k]);
        run_read(EOS_OP_UID_READ, 11);
        run_op(EOS_OP_WS_PROG, PROG, PROG, 0);
        run_op(EOS_OP_WS_LOAD, LOAD, 0, LOAD);
        exp_q.push_back(status_byte(1'b0));
        run_read(EOS_OP_STAT_READ, 1);
        end_sim();
    end
endmodule : eos_cmd_tb

// *** eos_host.sv ***
// host-side serial master model for the command link
`timescale 1ns/100ps
module eos_host (
    input  wire logic             sys_clk_i,
    input  wire logic             sda_i,
    input  wire logic             sda_oe_i,
    output eos_pkg::eos_pins_type pins_o
);
    import eos_pkg::*;

    logic float_q;
    logic line;

    // ------------------------------------------------------------
    // data line
    // ------------------------------------------------------------
    // released line toggles, so a stale bit can never pass as data
    always @(posedge sys_clk_i) float_q <= ~float_q;
    assign line = sda_oe_i ? sda_i : float_q;

    initial begin
        float_q = 1'b0;
        pins_o  = '{cs_n: 1'b1, scl: 1'b1, dc: 1'b0, sdi: 1'b0};
    end

    // ------------------------------------------------------------
    // link tasks, all changes at falling system edges
    // ------------------------------------------------------------
    task automatic ticks(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : ticks

    task automatic select(input logic on);
        ticks(4);
        pins_o.cs_n = ~on;
        ticks(4);
    endtask : select

    // four clocks per half period gives the 160 ns link clock
    task automatic xfer(input logic dc, input logic [7:0] tx, output logic [7:0] rx);
        pins_o.dc = dc;
        ticks(4);
        for (int i = 7; i >= 0; i--) begin
            pins_o.scl = 1'b0;
            pins_o.sdi = tx[i];
            ticks(4);
            rx[i]      = line;
            pins_o.scl = 1'b1;
            ticks(4);
        end
    endtask : xfer
endmodule : eos_host

// *** eos_pkg.sv ***
// package: constants and types for the status, read-back and waveform nonvolatile command slice
package eos_pkg;

    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] EOS_OP_OPT_READ  = 8'h2D;
    localparam logic [7:0] EOS_OP_UID_READ  = 8'h2E;
    localparam logic [7:0] EOS_OP_STAT_READ = 8'h2F;
    localparam logic [7:0] EOS_OP_WS_PROG   = 8'h30;
    localparam logic [7:0] EOS_OP_WS_LOAD   = 8'h31;

    // ------------------------------------------------------------
    // status byte layout
    // ------------------------------------------------------------
    localparam int         EOS_ST_HV_POS   = 5;
    localparam int         EOS_ST_VCI_POS  = 4;
    localparam int         EOS_ST_BUSY_POS = 2;
    localparam logic [1:0] EOS_CHIP_ID_DEF = 2'h2;  // arbitrary value

    // ------------------------------------------------------------
    // read-back lengths
    // ------------------------------------------------------------
    localparam logic [3:0] EOS_OPT_BYTES = 4'hB;
    localparam logic [3:0] EOS_UID_BYTES = 4'hA;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          EOS_CLK_MHZ        = 50;
    localparam int          EOS_WS_PROG_US     = 100;
    localparam int          EOS_WS_LOAD_US     = 10;
    localparam int          EOS_WS_PROG_CYC    = EOS_WS_PROG_US * EOS_CLK_MHZ;
    localparam logic [15:0] EOS_WS_LOAD_CYC    = 16'(EOS_WS_LOAD_US * EOS_CLK_MHZ);

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] EOS_CMD_RST = 8'h00;
    localparam logic [2:0] EOS_BIT_RST = 3'h0;
    localparam logic [3:0] EOS_IDX_RST = 4'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic cs_n;
        logic scl;
        logic dc;
        logic sdi;
    } eos_pins_type;

    typedef struct packed {
        logic [7:0]      vcom_sel;
        logic [7:0]      vcom_reg;
        logic [4:0][7:0] disp_mode;
        logic [3:0][7:0] ws_version;
    } eos_opts_type;

    typedef logic [9:0][7:0] eos_uid_type;

    typedef enum logic [1:0] {
        EOS_IDLE,
        EOS_PROG,
        EOS_LOAD
    } eos_state_type;

endpackage : eos_pkg
